// [sdw_supervisor.v]
// Self-diagnosis supervisor with cycle supervision timer and Wishbone regs
//
// Summary of operation
// - Each error lands in one class only
// - Failure error moves Control/Standby to Failure
// - Failure stops I/O, status keeps flowing
// - Partner failure makes standby take control
// - Unserved output module holds or forces off
// - Alarm keeps mode, raises forwarded warning
// - I/O alarm keeps mode, raises forwarded warning
// - Redundant I/O fault switches to partner I/O
// - Single input fault freezes last value, flags
// - CPU and power failures stop processor, alarm
// - Redundant-set comm and all I/O errors alarm, processor runs
// - Checks run at one fixed schedule of 1024 cycles
// - Diagnosis results evaluated every execution cycle
// - Per-module lamps plus three summary lamps
// - Comm errors classed by redundancy setting
// - CPU chassis mismatch flags and fails
// - I/O chassis mismatch marks signals bad
// - Timer counts clock, compares to timeout
// - Timer counts up after initialization
// - Timeout declares failure with alarm
// - Every module timer behaves the same
`timescale 1ns/1ps
`default_nettype none
`include "sdw_map.vh"

module sdw_supervisor #(
  parameter        CHANNELS    = 8,
  parameter        AWIDTH      = 16,
  parameter [31:0] TIMEOUT_CYC = `SDW_TIMEOUT_CYC,
  parameter        OUT_OFF     = 1'b0
) (
  // Clock, reset, enable
  input  wire                       clk,
  input  wire                       srst,
  input  wire                       clkEn,
  // Wishbone classic slave
  input  wire                       wb_cyc_i,
  input  wire                       wb_stb_i,
  input  wire                       wb_we_i,
  input  wire [7:0]                 wb_adr_i,
  input  wire [3:0]                 wb_sel_i,
  input  wire [31:0]                wb_dat_i,
  output reg  [31:0]                wb_dat_o,
  output reg                        wb_ack_o,
  // Hardware error pins (asynchronous)
  input  wire [`SDW_SRC_W-1:0]      hwErr,
  input  wire                       partnerFail,
  input  wire                       outModuleLinkLost,
  input  wire                       redIoFault,
  // Single input channels
  input  wire [CHANNELS*AWIDTH-1:0] inputLive,
  input  wire [CHANNELS-1:0]        inputFault,
  output wire [CHANNELS*AWIDTH-1:0] inputHeld,
  output reg  [CHANNELS-1:0]        inputErrFlag,
  // Mode and indicators
  output reg  [1:0]                 mode,
  output reg                        cpuHalt,
  output reg                        ioEnable,
  output reg                        statusTxEnable,
  output reg                        outEnable,
  output reg                        outForceOff,
  output reg                        ioUsePartner,
  output reg                        ioBadQuality,
  output reg                        ledFailure,
  output reg                        ledAlarm,
  output reg                        ledIoAlarm,
  output reg  [`SDW_SRC_W-1:0]      moduleLed,
  output reg                        warnForward,
  output reg                        timeoutFlag,
  output reg                        cycleTick
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg  [15:0]             ctrl;
  reg  [`SDW_SRC_W-1:0]   swErr;
  reg  [`SDW_SRC_W-1:0]   errLatch;
  reg  [31:0]             timeoutReg;
  reg  [31:0]             cstCount;
  reg                     clearReq;
  reg  [15:0]             schedCount;
  reg                     initSeen;
  reg  [1:0]              next_mode;
  wire [`SDW_SRC_W-1:0]   hwErrSync;
  wire [2:0]              pinSync;
  wire [`SDW_SRC_W-1:0]   srcNow;
  wire                    failNow;
  wire                    alarmNow;
  wire                    ioAlarmNow;
  wire                    wbReq;
  wire                    wbWrite;
  wire                    initDone;
  wire                    redCfg;

  assign initDone = ctrl[`SDW_CTRL_INITDONE];
  assign redCfg   = ctrl[`SDW_CTRL_REDCFG];

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  sdw_sync #(
    .WIDTH (`SDW_SRC_W)
  ) uErrSync (
    .clk     (clk),
    .srst    (srst),
    .clkEn   (clkEn),
    .asyncIn (hwErr),
    .syncOut (hwErrSync)
  );

  sdw_sync #(
    .WIDTH (3)
  ) uPinSync (
    .clk     (clk),
    .srst    (srst),
    .clkEn   (clkEn),
    .asyncIn ({partnerFail, outModuleLinkLost, redIoFault}),
    .syncOut (pinSync)
  );

  // ------------------------------------------------------------
  // Error classification
  // ------------------------------------------------------------
  // Sources from hardware pins and software set register together
  assign srcNow = hwErrSync | swErr;

  // Comm errors are fatal only without a redundant partner
  assign failNow = srcNow[`SDW_SRC_CPU] | srcNow[`SDW_SRC_PSU]
                 | srcNow[`SDW_SRC_CHASSIS]
                 | srcNow[`SDW_SRC_CST]
                 | (srcNow[`SDW_SRC_COMM] & ~redCfg);
  assign alarmNow = srcNow[`SDW_SRC_MINOR]
                  | (srcNow[`SDW_SRC_COMM] & redCfg);
  assign ioAlarmNow = srcNow[`SDW_SRC_IO]
                    | srcNow[`SDW_SRC_IOCHASSIS];

  // ------------------------------------------------------------
  // Diagnosis schedule tick
  // ------------------------------------------------------------
  // Stands in for the constant-period execution cycle; evaluation of
  // summary indicators is aligned to it
  always @(posedge clk) begin
    if (srst) begin
      schedCount <= 16'h0000;
      cycleTick  <= 1'b0;
    end else if (clkEn) begin
      cycleTick <= (schedCount == `SDW_SCHED_CYC - 1);
      if (schedCount == `SDW_SCHED_CYC - 1) begin
        schedCount <= 16'h0000;
      end else begin
        schedCount <= schedCount + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Cycle supervision timer
  // ------------------------------------------------------------
  // Same counter, clear and timeout as every module timer
  always @(posedge clk) begin
    if (srst) begin
      cstCount    <= 32'h00000000;
      timeoutFlag <= 1'b0;
    end else if (clkEn) begin
      if (!initDone) begin
        cstCount <= 32'h00000000;
      end else if (timeoutFlag) begin
        cstCount <= cstCount;
      end else if (cstCount >= timeoutReg - 32'h00000001) begin
        timeoutFlag <= 1'b1;
      end else if (clearReq) begin
        cstCount <= 32'h00000000;
      end else begin
        cstCount <= cstCount + 32'h00000001;
      end
    end
  end

  // ------------------------------------------------------------
  // Sticky error record
  // ------------------------------------------------------------
  // A new event wins over a software clear in the same cycle
  always @(posedge clk) begin
    if (srst) begin
      errLatch <= {`SDW_SRC_W{1'b0}};
    end else if (clkEn) begin
      errLatch <= srcNow | ({`SDW_SRC_W{timeoutFlag}} &
                            (`SDW_SRC_W'h1 << `SDW_SRC_CST))
                | (errLatch & ~((wbWrite &&
                    wb_adr_i == `SDW_REG_ERRLATCH) ?
                    wb_dat_i[`SDW_SRC_W-1:0] : {`SDW_SRC_W{1'b0}}));
    end
  end

  // ------------------------------------------------------------
  // Mode machine
  // ------------------------------------------------------------
  always @* begin
    next_mode = mode;
    case (mode)
      `SDW_MODE_INIT: begin
        if (initDone) begin
          next_mode = ctrl[`SDW_CTRL_PRIMARY] ? `SDW_MODE_CONTROL
                                              : `SDW_MODE_STANDBY;
        end
      end
      `SDW_MODE_CONTROL: begin
        if (failNow || timeoutFlag) begin
          next_mode = `SDW_MODE_FAILURE;
        end
      end
      `SDW_MODE_STANDBY: begin
        if (failNow || timeoutFlag) begin
          next_mode = `SDW_MODE_FAILURE;
        end else if (redCfg && pinSync[2]) begin
          next_mode = `SDW_MODE_CONTROL;
        end
      end
      `SDW_MODE_FAILURE: begin
        // Only a fresh initialization leaves failure
        if (!initDone) begin
          next_mode = `SDW_MODE_INIT;
        end
      end
      default: begin
        next_mode = `SDW_MODE_FAILURE;
      end
    endcase
    // Alarm and I/O alarm never change mode
  end

  always @(posedge clk) begin
    if (srst) begin
      mode <= `SDW_MODE_INIT;
    end else if (clkEn) begin
      mode <= next_mode;
    end
  end

  // ------------------------------------------------------------
  // Mode-dependent outputs and indicators
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      cpuHalt        <= 1'b0;
      ioEnable       <= 1'b0;
      statusTxEnable <= 1'b0;
      outEnable      <= 1'b0;
      outForceOff    <= 1'b0;
      ioUsePartner   <= 1'b0;
      ioBadQuality   <= 1'b0;
      ledFailure     <= 1'b0;
      ledAlarm       <= 1'b0;
      ledIoAlarm     <= 1'b0;
      moduleLed      <= {`SDW_SRC_W{1'b0}};
      warnForward    <= 1'b0;
    end else if (clkEn) begin
      // Processor halts only on fatal class
      cpuHalt  <= (mode == `SDW_MODE_FAILURE);
      ioEnable <= (mode == `SDW_MODE_CONTROL);
      statusTxEnable <= (mode != `SDW_MODE_INIT);
      // Output module served only while a controller drives it
      outEnable   <= (mode == `SDW_MODE_CONTROL) && !pinSync[1];
      outForceOff <= pinSync[1] && OUT_OFF;
      // Redundant I/O fault moves traffic to partner
      if (redCfg && pinSync[0] && mode == `SDW_MODE_CONTROL) begin
        ioUsePartner <= 1'b1;
      end else if (!initDone) begin
        ioUsePartner <= 1'b0;
      end
      ioBadQuality <= srcNow[`SDW_SRC_IOCHASSIS];
      moduleLed    <= errLatch;
      if (cycleTick) begin
        ledFailure  <= (mode == `SDW_MODE_FAILURE);
        ledAlarm    <= |(errLatch & ((`SDW_SRC_W'h1 << `SDW_SRC_MINOR) |
                         (redCfg ? (`SDW_SRC_W'h1 << `SDW_SRC_COMM)
                                 : {`SDW_SRC_W{1'b0}})));
        ledIoAlarm  <= |(errLatch & ((`SDW_SRC_W'h1 << `SDW_SRC_IO) |
                         (`SDW_SRC_W'h1 << `SDW_SRC_IOCHASSIS)));
        warnForward <= alarmNow | ioAlarmNow;
      end
    end
  end

  // ------------------------------------------------------------
  // Single input hold
  // ------------------------------------------------------------
  // Fault flags come from same-clock logic, so no synchroniser
  always @(posedge clk) begin
    if (srst) begin
      inputErrFlag <= {CHANNELS{1'b0}};
    end else if (clkEn) begin
      inputErrFlag <= inputFault;
    end
  end

  sdw_hold_mem #(
    .CHANNELS (CHANNELS),
    .WIDTH    (AWIDTH)
  ) uHold (
    .clk     (clk),
    .srst    (srst),
    .clkEn   (clkEn),
    .liveIn  (inputLive),
    .freeze  (inputFault),
    .heldOut (inputHeld)
  );

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  // One wait state: ack rises the cycle after the request is seen
  assign wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wbReq && wb_we_i && clkEn;

  always @(posedge clk) begin
    if (srst) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      ctrl       <= `SDW_CTRL_RESET;
      swErr      <= {`SDW_SRC_W{1'b0}};
      timeoutReg <= TIMEOUT_CYC;
      clearReq   <= 1'b0;
    end else if (clkEn) begin
      wb_ack_o <= wbReq;
      clearReq <= 1'b0;
      if (wbWrite) begin
        case (wb_adr_i)
          `SDW_REG_CTRL: begin
            if (wb_sel_i[0]) begin
              ctrl[7:0] <= wb_dat_i[7:0];
            end
          end
          `SDW_REG_ERRSET: begin
            if (wb_sel_i[0]) begin
              swErr <= wb_dat_i[`SDW_SRC_W-1:0];
            end
          end
          `SDW_REG_CLEAR: begin
            clearReq <= wb_dat_i[0];
          end
          default: begin
            clearReq <= 1'b0;
          end
        endcase
      end
      // Timeout threshold is fixed at build time, register is read-only
      case (wb_adr_i)
        `SDW_REG_CTRL:     wb_dat_o <= {16'h0000, ctrl};
        `SDW_REG_STATUS:   wb_dat_o <= {26'h0000000, timeoutFlag,
                                        ioUsePartner, cpuHalt,
                                        ledIoAlarm, mode};
        `SDW_REG_ERRSET:   wb_dat_o <= {23'h000000, swErr};
        `SDW_REG_ERRLATCH: wb_dat_o <= {23'h000000, errLatch};
        `SDW_REG_TIMEOUT:  wb_dat_o <= timeoutReg;
        `SDW_REG_COUNT:    wb_dat_o <= cstCount;
        `SDW_REG_INHOLD:   wb_dat_o <= {{(32-CHANNELS){1'b0}}, inputErrFlag};
        default:           wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// [sdw_map.vh]
// Register map, field positions and timing constants of the supervisor
`ifndef SDW_MAP_VH
`define SDW_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SDW_REG_CTRL      8'h00
`define SDW_REG_STATUS    8'h04
`define SDW_REG_ERRSET    8'h08
`define SDW_REG_ERRLATCH  8'h0C
`define SDW_REG_TIMEOUT   8'h10
`define SDW_REG_COUNT     8'h14
`define SDW_REG_CLEAR     8'h18
`define SDW_REG_INHOLD    8'h1C

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define SDW_CTRL_INITDONE 0
`define SDW_CTRL_REDCFG   1
`define SDW_CTRL_PRIMARY  2
`define SDW_CTRL_RESET    16'h0000

// ------------------------------------------------------------
// Error source bit positions (software raised set)
// ------------------------------------------------------------
`define SDW_SRC_CPU       0
`define SDW_SRC_PSU       1
`define SDW_SRC_CHASSIS   2
`define SDW_SRC_COMM      3
`define SDW_SRC_MINOR     4
`define SDW_SRC_IOCHASSIS 5
`define SDW_SRC_IO        6
`define SDW_SRC_CST       7
`define SDW_SRC_W         8

// ------------------------------------------------------------
// Modes
// ------------------------------------------------------------
`define SDW_MODE_INIT     2'h0
`define SDW_MODE_CONTROL  2'h1
`define SDW_MODE_STANDBY  2'h2
`define SDW_MODE_FAILURE  2'h3

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SDW_CLK_HZ        50000000
`define SDW_TIMEOUT_MS    100
`define SDW_TIMEOUT_CYC   ((`SDW_CLK_HZ / 1000) * `SDW_TIMEOUT_MS)
`define SDW_SCHED_CYC     1024

`endif

// [sdw_sync.v]
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none

module sdw_sync #(
  parameter WIDTH = 8
) (
  // Clocking
  input  wire             clk,
  input  wire             srst,
  input  wire             clkEn,
  // Data
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;

  // ------------------------------------------------------------
  // Synchroniser chain
  // ------------------------------------------------------------
  // First stage feeds only the second, to bound metastability
  always @(posedge clk) begin
    if (srst) begin
      stage1  <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule
`default_nettype wire

// [sdw_hold_mem.v]
// Last-good-value store for single input channels
`timescale 1ns/1ps
`default_nettype none

module sdw_hold_mem #(
  parameter CHANNELS = 8,
  parameter WIDTH    = 16
) (
  // Clocking
  input  wire                     clk,
  input  wire                     srst,
  input  wire                     clkEn,
  // Channel data
  input  wire [CHANNELS*WIDTH-1:0] liveIn,
  input  wire [CHANNELS-1:0]       freeze,
  output reg  [CHANNELS*WIDTH-1:0] heldOut
);

  // ------------------------------------------------------------
  // Per-channel hold registers
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gHold
      // A frozen channel keeps the value from before the fault
      always @(posedge clk) begin
        if (srst) begin
          heldOut[ch*WIDTH +: WIDTH] <= {WIDTH{1'b0}};
        end else if (clkEn && !freeze[ch]) begin
          heldOut[ch*WIDTH +: WIDTH] <= liveIn[ch*WIDTH +: WIDTH];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [sdw_supervisor_props.sv]
// Port-level assertion checker for the self-diagnosis supervisor
`timescale 1ns/1ps
`default_nettype none
`include "sdw_map.vh"

module sdw_supervisor_props (
  // Clocking
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       clkEn,
  // Bus handshake
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Mode and indicators
  input wire logic [1:0] mode,
  input wire logic       cpuHalt,
  input wire logic       ioEnable,
  input wire logic       statusTxEnable,
  input wire logic       ledFailure,
  input wire logic       ledAlarm,
  input wire logic       ledIoAlarm,
  input wire logic       warnForward,
  input wire logic       timeoutFlag,
  input wire logic       cycleTick
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // ----------------------------------------------------------
  // Schedule tick spacing
  // ----------------------------------------------------------
  logic [10:0] tickGap;
  logic        tickSeen;

  // Gap is only trusted after one tick, the first one has no origin
  always_ff @(posedge clk) begin
    if (srst) begin
      tickGap  <= 11'h000;
      tickSeen <= 1'b0;
    end else if (clkEn) begin
      if (cycleTick) begin
        tickGap  <= 11'h000;
        tickSeen <= 1'b1;
      end else begin
        tickGap <= tickGap + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn
    |=> wb_ack_o) else $error("bus request not acknowledged next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  fail_halt_a: assert property (
    mode == `SDW_MODE_FAILURE ##1 mode == `SDW_MODE_FAILURE
    |-> cpuHalt && !ioEnable && statusTxEnable)
    else $error("failure mode without halt or with status stopped");
  fail_exit_a: assert property (mode == `SDW_MODE_FAILURE
    |=> mode == `SDW_MODE_FAILURE || mode == `SDW_MODE_INIT)
    else $error("failure mode left for an operating mode");
  timeout_fail_a: assert property ($rose(timeoutFlag)
    |=> mode == `SDW_MODE_FAILURE)
    else $error("timeout without failure mode");
  timeout_hold_a: assert property (timeoutFlag |=> timeoutFlag)
    else $error("timeout flag dropped without reset");
  tick_period_a: assert property (tickSeen && cycleTick
    |-> tickGap == 11'h3FF) else $error("schedule tick spacing wrong");
  led_update_a: assert property (
    $changed({ledFailure, ledAlarm, ledIoAlarm, warnForward})
    |-> cycleTick || $past(cycleTick))
    else $error("summary lamps changed off the schedule tick");
endmodule

bind sdw_supervisor sdw_supervisor_props u_props (
  .clk(clk), .srst(srst), .clkEn(clkEn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .mode(mode), .cpuHalt(cpuHalt), .ioEnable(ioEnable),
  .statusTxEnable(statusTxEnable), .ledFailure(ledFailure),
  .ledAlarm(ledAlarm), .ledIoAlarm(ledIoAlarm),
  .warnForward(warnForward), .timeoutFlag(timeoutFlag),
  .cycleTick(cycleTick)
);
`default_nettype wire

// [test_sdw_supervisor.sv]
// Self-checking bench for the self-diagnosis supervisor
`timescale 1ns/1ps
`default_nettype none
`include "sdw_map.vh"

module test_sdw_supervisor;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  localparam int TMO = 1500; // Short timeout keeps the run brief
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic         wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [7:0]   wbAdr = 8'h00;
  logic [31:0]  wbDatI = 32'h0, wbDatO, rd, prev;
  logic [8:0]   hwErr = 9'h000, moduleLed;
  logic         partnerFail = 1'b0, linkLost = 1'b0, redIoFault = 1'b0;
  logic [127:0] inputLive = 128'h0, inputHeld;
  logic [7:0]   inputFault = 8'h00, inputErrFlag;
  logic [1:0]   mode;
  logic         cpuHalt, ioEnable, statusTx, outEnable, outForceOff;
  logic         ioUsePartner, ioBadQuality, ledFailure, ledAlarm;
  logic         ledIoAlarm, warnForward, timeoutFlag, cycleTick;
  int           failures = 0, n_compared = 0, k, n;
  int           srcs[3] = '{4, 6, 3};
  logic [2:0]   exps[3] = '{3'h2, 3'h1, 3'h2};

  always #10 clk = ~clk;

  sdw_supervisor #(.TIMEOUT_CYC(TMO), .OUT_OFF(1'b0)) dut (
    .clk(clk), .srst(srst), .clkEn(1'b1),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .hwErr(hwErr), .partnerFail(partnerFail), .outModuleLinkLost(linkLost),
    .redIoFault(redIoFault), .inputLive(inputLive), .inputFault(inputFault),
    .inputHeld(inputHeld), .inputErrFlag(inputErrFlag), .mode(mode),
    .cpuHalt(cpuHalt), .ioEnable(ioEnable), .statusTxEnable(statusTx),
    .outEnable(outEnable), .outForceOff(outForceOff),
    .ioUsePartner(ioUsePartner), .ioBadQuality(ioBadQuality),
    .ledFailure(ledFailure), .ledAlarm(ledAlarm), .ledIoAlarm(ledIoAlarm),
    .moduleLed(moduleLed), .warnForward(warnForward),
    .timeoutFlag(timeoutFlag), .cycleTick(cycleTick)
  );

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic pause(input int c);
    repeat (c) @(posedge clk);
  endtask

  // One classic cycle; data and ack are taken at the ack edge
  task automatic wbx(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    int w;
    w = 0;
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbDatI <= d;
    do begin
      @(posedge clk);
      w++;
    end while (wbAck !== 1'b1 && w < 20);
    chk(32'(wbAck), 32'h1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  // Lamps move only on ticks; waiting two ticks covers sync latency,
  // and the timer is served before each so it never expires here
  task automatic tickw();
    int t;
    for (int j = 0; j < 2; j++) begin
      wbx(1'b1, `SDW_REG_CLEAR, 32'h1);
      t = 0;
      while (cycleTick !== 1'b1 && t < 1100) begin
        @(posedge clk);
        t++;
      end
      pause(3);
    end
  endtask

  task automatic rst();
    srst        <= 1'b1;
    hwErr       <= 9'h000;
    partnerFail <= 1'b0;
    pause(3);
    srst <= 1'b0;
  endtask

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Watchdog against a hung sequence
  // ----------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    results();
  end

  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    rst();
    chk(32'(mode), 32'h0);
    wbx(1'b0, `SDW_REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    wbx(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    wbx(1'b0, `SDW_REG_TIMEOUT, 32'h0);
    chk(rd, TMO);
    // Redundant primary: control mode, timer counting up
    wbx(1'b1, `SDW_REG_CTRL, 32'h7);
    pause(4);
    chk(32'({mode, cpuHalt, ioEnable, outEnable}), 32'hB);
    wbx(1'b0, `SDW_REG_COUNT, 32'h0);
    prev = rd;
    wbx(1'b0, `SDW_REG_COUNT, 32'h0);
    chk(32'(rd > prev), 32'h1);
    wbx(1'b1, `SDW_REG_CLEAR, 32'h1);
    wbx(1'b0, `SDW_REG_COUNT, 32'h0);
    chk(32'(rd < 32'h8), 32'h1);
    for (k = 0; k < 3; k++) begin
      pause(1000);
      wbx(1'b1, `SDW_REG_CLEAR, 32'h1);
    end
    chk(32'(timeoutFlag), 32'h0);
    // Minor, I/O and redundant comm errors keep the mode
    for (k = 0; k < 3; k++) begin
      wbx(1'b1, `SDW_REG_ERRSET, 32'h1 << srcs[k]);
      tickw();
      chk(32'({mode, ledFailure, ledAlarm, ledIoAlarm, warnForward}),
          32'({2'h1, exps[k], 1'b1}));
      wbx(1'b1, `SDW_REG_ERRSET, 32'h0);
      wbx(1'b1, `SDW_REG_ERRLATCH, 32'h1FF);
    end
    hwErr <= 9'h040;
    tickw();
    wbx(1'b0, `SDW_REG_STATUS, 32'h0);
    chk(32'(rd[5:0]), 32'h05);
    hwErr      <= 9'h020;
    redIoFault <= 1'b1;
    linkLost   <= 1'b1;
    pause(8);
    chk(32'({mode, ioBadQuality, ioUsePartner, outForceOff, outEnable}),
        32'h1C);
    // Single input fault freezes the last good value
    inputLive  <= {8{16'h1234}};
    pause(3);
    inputFault <= 8'h01;
    pause(2);
    inputLive  <= {8{16'hBEEF}};
    pause(3);
    chk(inputHeld[31:0], 32'hBEEF1234);
    chk(32'(inputErrFlag), 32'h1);
    // Fatal sources, comm fatal when not redundant
    for (k = 0; k < 4; k++) begin
      rst();
      wbx(1'b1, `SDW_REG_CTRL, 32'h5);
      wbx(1'b1, `SDW_REG_ERRSET, 32'h1 << k);
      pause(6);
      chk(32'({mode, cpuHalt, ioEnable, statusTx}), 32'h1D);
      chk(32'(moduleLed), 32'h1 << k);
    end
    rst();
    wbx(1'b1, `SDW_REG_CTRL, 32'h3);
    pause(4);
    chk(32'(mode), 32'h2);
    hwErr <= 9'h001;
    pause(8);
    chk(32'(mode), 32'h3);
    rst();
    wbx(1'b1, `SDW_REG_CTRL, 32'h3);
    partnerFail <= 1'b1;
    pause(8);
    chk(32'(mode), 32'h1);
    // Timer left unserved
    rst();
    wbx(1'b1, `SDW_REG_CTRL, 32'h5);
    n = 0;
    while (timeoutFlag !== 1'b1 && n < TMO + 100) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= TMO - 8 && n <= TMO + 8), 32'h1);
    pause(3);
    chk(32'({mode, cpuHalt}), 32'h7);
    wbx(1'b1, `SDW_REG_CLEAR, 32'h1);
    pause(4);
    chk(32'(timeoutFlag), 32'h1);
    wbx(1'b1, `SDW_REG_CTRL, 32'h0);
    pause(4);
    chk(32'({mode, timeoutFlag}), 32'h1);
    results();
  end
endmodule
`default_nettype wire
